// ### include/ooo_params.svh
// Purpose: Shared constants of the dispatch and retirement control
// Assumes: Included by the package and every design file
// Notes: Counts are in entries or clk cycles
`ifndef OOO_PARAMS_SVH
`define OOO_PARAMS_SVH
`define CBUF_DEPTH 126
`define TAG_W 7
`define ISSUE_W 6
`define ISSUE_PORTS 4
`define RETIRE_W 3
`define LD_MAX 48
`define ST_MAX 24
`define LD_CNT_W 6
`define ST_CNT_W 5
`define PRED_ENTRIES 4096
`define PRED_IDX_W 12
`define PRED_IDX_LSB 2
`define LINE_BYTES 64
`define LINE_LSB 6
`define SECTOR_LINES 2
`define FIFO_DEPTH 8
`define TRACE_N 4
`define ARCH_INT_N 8
`define ARCH_FP_N 8
`define ARCH_N 16
`endif

// ### include/ooo_pkg.sv
// Purpose: Types carried between front end, core and execution pipelines
// Assumes: ooo_params.svh for widths
// Notes: Destination bit 3 selects the floating-point register group
`include "ooo_params.svh"
package ooo_pkg;
  typedef enum logic [1:0] {
    CLS_ALU = 2'b00,
    CLS_FP = 2'b01,
    CLS_LD = 2'b10,
    CLS_ST = 2'b11
  } uop_cls_t;

  typedef struct packed {
    logic [31:0] pc;
    uop_cls_t cls;
    logic is_br;
    logic [31:0] pred_tgt;
    logic has_dst;
    logic [3:0] dst;
  } uop_t;

  typedef struct packed {
    logic valid;
    logic [`TAG_W-1:0] tag;
    uop_t uop;
  } issue_t;

  typedef struct packed {
    logic valid;
    logic [`TAG_W-1:0] tag;
    logic exc;
    logic mispred;
    logic [31:0] tgt;
    logic [31:0] data;
  } cmpl_t;

  typedef struct packed {
    logic valid;
    logic issued;
    logic done;
    logic exc;
    logic mispred;
    logic [31:0] tgt;
    logic [31:0] data;
    uop_t uop;
  } cbuf_ent_t;
endpackage

// ### design/uop_fifo.sv
// Purpose: Ordered buffer between front end and allocation
// Assumes: Single clock, synchronous active-low reset
// Notes: Flush drops all held and incoming words
`timescale 1ns/1ps
`include "ooo_params.svh"
module uop_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
      if (pop) rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL);
    end
  end

  a_fifo_full: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_r == FULL) |-> !in_ready) else $error("fifo accepts while full");
endmodule

// ### design/branch_target_predictor_table.sv
// Purpose: Tagged branch target lookup by linear address
// Assumes: Lookup result one cycle after the address
// Notes: Update and lookup of one index in one cycle returns the old entry
`timescale 1ns/1ps
`include "ooo_params.svh"
module branch_target_predictor_table #(
  parameter int ENTRIES = `PRED_ENTRIES,
  parameter int IW = `PRED_IDX_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] lk_pc,
  output logic hit_r,
  output logic [31:0] tgt_r,
  input wire logic upd_en,
  input wire logic [31:0] upd_pc,
  input wire logic [31:0] upd_tgt
);
  localparam int TGW = 32 - IW - `PRED_IDX_LSB;
  logic [ENTRIES-1:0] valid_r;
  logic [31:0] tgt_mem [ENTRIES];
  logic [TGW-1:0] tag_mem [ENTRIES];
  logic [IW-1:0] li, ui;

  assign li = lk_pc[`PRED_IDX_LSB +: IW];
  assign ui = upd_pc[`PRED_IDX_LSB +: IW];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_r <= '0;
    end else if (upd_en) begin
      valid_r[ui] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (upd_en) begin
      tgt_mem[ui] <= upd_tgt;
      tag_mem[ui] <= upd_pc[31:32-TGW];
    end
  end

  // Lookup by linear address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hit_r <= 1'b0;
      tgt_r <= '0;
    end else begin
      hit_r <= valid_r[li] && (tag_mem[li] == lk_pc[31:32-TGW]);
      tgt_r <= tgt_mem[li];
    end
  end

  a_pred_learn: assert property (@(posedge clk) disable iff (!rst_n)
    (upd_en ##1 (lk_pc == $past(upd_pc) && !upd_en)) |=> (hit_r && tgt_r == $past(upd_tgt, 2)))
    else $error("updated target not found");
endmodule

// ### design/ooo_dispatch_retire_control.sv
// Purpose: In-order allocation, out-of-order issue and in-order retirement
// Assumes: clk is the ALU clock; the core rate is every second edge
// Notes: Pipelines drop their work on redirect_r or fault_r
`timescale 1ns/1ps
`include "ooo_params.svh"
module ooo_dispatch_retire_control #(
  parameter int CBUF_N = `CBUF_DEPTH,
  parameter int LD_MAX = `LD_MAX,
  parameter int ST_MAX = `ST_MAX,
  parameter int TRACE_N = `TRACE_N,
  parameter int FIFO_D = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fe_valid,
  input wire ooo_pkg::uop_t fe_uop,
  output logic fe_ready,
  input wire logic [31:0] lk_pc,
  output logic fetch_req,
  output logic [31-`LINE_LSB:0] fetch_line,
  output logic fetch_sector,
  input wire logic br_active,
  input wire logic [31:0] br_next_pc,
  input wire logic trace_wr,
  input wire logic [31:0] trace_wr_pc,
  output logic trace_src_r,
  output logic [((TRACE_N > 1) ? $clog2(TRACE_N) : 1)-1:0] trace_idx_r,
  output ooo_pkg::issue_t [`ISSUE_PORTS-1:0] iss_r,
  input wire ooo_pkg::cmpl_t [`ISSUE_PORTS-1:0] cmp,
  output logic [`RETIRE_W-1:0] ret_valid_r,
  output logic [`RETIRE_W-1:0] st_commit_r,
  output logic [`ARCH_N-1:0][31:0] arch_r,
  output logic redirect_r,
  output logic [31:0] redirect_pc_r,
  output logic fault_r,
  output logic [31:0] fault_pc_r
);
  localparam int TW = (TRACE_N > 1) ? $clog2(TRACE_N) : 1;
  localparam logic [6:0] CBUF_N7 = 7'(CBUF_N);

  logic core_en_r, fp_en_r;
  ooo_pkg::cbuf_ent_t cbuf_r [CBUF_N];
  logic [6:0] head_r, tail_r, cnt_r;
  logic [`LD_CNT_W-1:0] ld_cnt_r;
  logic [`ST_CNT_W-1:0] st_cnt_r;
  ooo_pkg::uop_t q_data;
  logic q_valid, alloc;
  logic [CBUF_N-1:0] ret_clr, iss_hit;
  logic [`RETIRE_W-1:0] ret_mask;
  logic [1:0] ret_n, ret_ld, ret_st;
  logic flush_now, fault_now, mis_now;
  logic [31:0] flush_pc, mis_old_tgt;
  ooo_pkg::issue_t [`ISSUE_PORTS-1:0] iss_nxt;
  logic [TRACE_N-1:0] tr_v_r, tr_purge;
  logic [31:0] tr_pc_r [TRACE_N];
  logic [TW-1:0] tr_wp_r, tr_hit_idx;
  logic tr_hit;
  logic pred_upd_r;
  logic [31:0] pred_upd_pc_r, pred_upd_tgt_r, pred_tgt;

  function automatic logic [6:0] wrap(input logic [6:0] a, input logic [6:0] b);
    logic [7:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, CBUF_N7}) s = s - {1'b0, CBUF_N7};
    return s[6:0];
  endfunction

  function automatic logic port_ok(input int p, input ooo_pkg::uop_cls_t c, input logic slow, input logic fp);
    if (p < 2) return c == ooo_pkg::CLS_ALU;
    if (p == 2) return slow && c == ooo_pkg::CLS_LD;
    return slow && (c == ooo_pkg::CLS_ST || (fp && c == ooo_pkg::CLS_FP));
  endfunction

  // Core rate enable from the ALU clock
  always_ff @(posedge clk) begin
    if (!rst_n) core_en_r <= 1'b0;
    else core_en_r <= ~core_en_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) fp_en_r <= 1'b1;
    else if (core_en_r) fp_en_r <= ~fp_en_r;
  end

  // Program-ordered buffer from the front end
  uop_fifo #(.WIDTH($bits(ooo_pkg::uop_t)), .DEPTH(FIFO_D)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(flush_now),
    .in_valid(fe_valid),
    .in_ready(fe_ready),
    .in_data(fe_uop),
    .out_valid(q_valid),
    .out_ready(alloc),
    .out_data(q_data)
  );

  // Branch target prediction and line fetch
  branch_target_predictor_table #(.ENTRIES(`PRED_ENTRIES), .IW(`PRED_IDX_W)) u_pred (
    .clk(clk),
    .rst_n(rst_n),
    .lk_pc(lk_pc),
    .hit_r(fetch_req),
    .tgt_r(pred_tgt),
    .upd_en(pred_upd_r),
    .upd_pc(pred_upd_pc_r),
    .upd_tgt(pred_upd_tgt_r)
  );
  assign fetch_line = pred_tgt[31:`LINE_LSB];
  assign fetch_sector = pred_tgt[`LINE_LSB];

  // Allocation in arrival order with load and store limits
  always_comb begin
    alloc = 1'b0;
    if (core_en_r && q_valid && !flush_now && cnt_r != CBUF_N7) begin
      if (q_data.cls == ooo_pkg::CLS_LD) alloc = (ld_cnt_r < `LD_CNT_W'(LD_MAX));
      else if (q_data.cls == ooo_pkg::CLS_ST) alloc = (st_cnt_r < `ST_CNT_W'(ST_MAX));
      else alloc = 1'b1;
    end
  end

  // Retirement window scanned from the oldest entry
  always_comb begin
    logic [6:0] idx;
    logic stop;
    idx = '0;
    stop = 1'b0;
    ret_mask = '0;
    ret_clr = '0;
    ret_ld = '0;
    ret_st = '0;
    flush_now = 1'b0;
    fault_now = 1'b0;
    mis_now = 1'b0;
    flush_pc = '0;
    mis_old_tgt = '0;
    for (int k = 0; k < `RETIRE_W; k++) begin
      idx = wrap(head_r, 7'(k));
      if (!stop && core_en_r && 7'(k) < cnt_r && cbuf_r[idx].done) begin
        if (cbuf_r[idx].exc) begin
          fault_now = 1'b1;
          flush_now = 1'b1;
          flush_pc = cbuf_r[idx].uop.pc;
          stop = 1'b1;
        end else begin
          ret_mask[k] = 1'b1;
          ret_clr[idx] = 1'b1;
          if (cbuf_r[idx].uop.cls == ooo_pkg::CLS_LD) ret_ld = ret_ld + 2'd1;
          if (cbuf_r[idx].uop.cls == ooo_pkg::CLS_ST) ret_st = ret_st + 2'd1;
          if (cbuf_r[idx].uop.is_br && cbuf_r[idx].mispred) begin
            mis_now = 1'b1;
            flush_now = 1'b1;
            flush_pc = cbuf_r[idx].tgt;
            mis_old_tgt = cbuf_r[idx].uop.pred_tgt;
            stop = 1'b1;
          end
        end
      end else begin
        stop = 1'b1;
      end
    end
    ret_n = 2'($countones(ret_mask));
  end

  // Oldest-first issue selection per port
  always_comb begin
    logic [CBUF_N-1:0] taken;
    logic [6:0] idx;
    logic found;
    taken = '0;
    idx = '0;
    found = 1'b0;
    iss_nxt = '0;
    for (int p = 0; p < `ISSUE_PORTS; p++) begin
      found = 1'b0;
      for (int i = 0; i < CBUF_N; i++) begin
        idx = wrap(head_r, 7'(i));
        if (!found && !flush_now && 7'(i) < cnt_r && cbuf_r[idx].valid && !cbuf_r[idx].issued && !taken[idx] &&
            port_ok(p, cbuf_r[idx].uop.cls, core_en_r, fp_en_r)) begin
          found = 1'b1;
          taken[idx] = 1'b1;
          iss_nxt[p].valid = 1'b1;
          iss_nxt[p].tag = idx;
          iss_nxt[p].uop = cbuf_r[idx].uop;
        end
      end
    end
    iss_hit = taken;
  end

  // In-order completion buffer entries
  for (genvar e = 0; e < CBUF_N; e++) begin : g_cbuf
    always_ff @(posedge clk) begin
      if (!rst_n || flush_now || ret_clr[e]) begin
        cbuf_r[e] <= '0;
      end else begin
        if (alloc && tail_r == 7'(e)) begin
          cbuf_r[e] <= '0;
          cbuf_r[e].valid <= 1'b1;
          cbuf_r[e].uop <= q_data;
        end
        if (iss_hit[e]) cbuf_r[e].issued <= 1'b1;
        for (int p = 0; p < `ISSUE_PORTS; p++) begin
          if (cmp[p].valid && cmp[p].tag == 7'(e) && cbuf_r[e].valid && cbuf_r[e].issued) begin
            cbuf_r[e].done <= 1'b1;
            cbuf_r[e].exc <= cmp[p].exc;
            cbuf_r[e].mispred <= cmp[p].mispred;
            cbuf_r[e].tgt <= cmp[p].tgt;
            cbuf_r[e].data <= cmp[p].data;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush_now) begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r <= '0;
    end else begin
      head_r <= wrap(head_r, {5'd0, ret_n});
      if (alloc) tail_r <= wrap(tail_r, 7'd1);
      cnt_r <= cnt_r + {6'd0, alloc} - {5'd0, ret_n};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush_now) begin
      ld_cnt_r <= '0;
      st_cnt_r <= '0;
    end else begin
      ld_cnt_r <= ld_cnt_r + `LD_CNT_W'(alloc && q_data.cls == ooo_pkg::CLS_LD) - `LD_CNT_W'(ret_ld);
      st_cnt_r <= st_cnt_r + `ST_CNT_W'(alloc && q_data.cls == ooo_pkg::CLS_ST) - `ST_CNT_W'(ret_st);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush_now) iss_r <= '0;
    else iss_r <= iss_nxt;
  end

  // Commit to memory and architectural registers in order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ret_valid_r <= '0;
      st_commit_r <= '0;
      arch_r <= '0;
    end else begin
      ret_valid_r <= ret_mask;
      for (int k = 0; k < `RETIRE_W; k++) begin
        st_commit_r[k] <= ret_mask[k] && cbuf_r[wrap(head_r, 7'(k))].uop.cls == ooo_pkg::CLS_ST;
        if (ret_mask[k] && cbuf_r[wrap(head_r, 7'(k))].uop.has_dst) begin
          arch_r[cbuf_r[wrap(head_r, 7'(k))].uop.dst] <= cbuf_r[wrap(head_r, 7'(k))].data;
        end
      end
    end
  end

  // Predictor training from retired branches
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pred_upd_r <= 1'b0;
      pred_upd_pc_r <= '0;
      pred_upd_tgt_r <= '0;
    end else begin
      pred_upd_r <= 1'b0;
      for (int k = 0; k < `RETIRE_W; k++) begin
        if (ret_mask[k] && cbuf_r[wrap(head_r, 7'(k))].uop.is_br) begin
          pred_upd_r <= 1'b1;
          pred_upd_pc_r <= cbuf_r[wrap(head_r, 7'(k))].uop.pc;
          pred_upd_tgt_r <= cbuf_r[wrap(head_r, 7'(k))].tgt;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      redirect_r <= 1'b0;
      redirect_pc_r <= '0;
      fault_r <= 1'b0;
      fault_pc_r <= '0;
    end else begin
      redirect_r <= mis_now;
      fault_r <= fault_now;
      if (mis_now) redirect_pc_r <= flush_pc;
      if (fault_now) fault_pc_r <= flush_pc;
    end
  end

  // Stored trace start addresses
  always_comb begin
    tr_hit = 1'b0;
    tr_hit_idx = '0;
    for (int t = 0; t < TRACE_N; t++) begin
      tr_purge[t] = mis_now && tr_v_r[t] && tr_pc_r[t] == mis_old_tgt;
      if (!tr_hit && tr_v_r[t] && tr_pc_r[t] == br_next_pc) begin
        tr_hit = 1'b1;
        tr_hit_idx = TW'(t);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tr_v_r <= '0;
      tr_wp_r <= '0;
    end else begin
      for (int t = 0; t < TRACE_N; t++) begin
        if (trace_wr && tr_wp_r == TW'(t)) tr_v_r[t] <= 1'b1;
        else if (tr_purge[t]) tr_v_r[t] <= 1'b0;
      end
      if (trace_wr) tr_wp_r <= (tr_wp_r == TW'(TRACE_N - 1)) ? '0 : tr_wp_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    for (int t = 0; t < TRACE_N; t++) begin
      if (trace_wr && tr_wp_r == TW'(t)) tr_pc_r[t] <= trace_wr_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush_now) begin
      trace_src_r <= 1'b0;
      trace_idx_r <= '0;
    end else if (br_active) begin
      trace_src_r <= tr_hit;
      if (tr_hit) trace_idx_r <= tr_hit_idx;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_alloc_order: assert property (
    alloc |=> tail_r == wrap($past(tail_r), 7'd1)) else $error("allocation out of order");
  a_trace_switch: assert property (
    (br_active && tr_hit && !flush_now) |=> trace_src_r) else $error("trace not selected");
  a_slow_port: assert property (
    (iss_r[2].valid || iss_r[3].valid) |-> $past(core_en_r)) else $error("slow port off core rate");
  a_fp_gap: assert property (
    (iss_r[3].valid && iss_r[3].uop.cls == ooo_pkg::CLS_FP) |=>
    (!(iss_r[3].valid && iss_r[3].uop.cls == ooo_pkg::CLS_FP))[*3]) else $error("fp issued too often");
  a_cbuf_bound: assert property (
    cnt_r <= CBUF_N7) else $error("too many in flight");
  a_lsq_bound: assert property (
    ld_cnt_r <= `LD_CNT_W'(LD_MAX) && st_cnt_r <= `ST_CNT_W'(ST_MAX)) else $error("memory op limit");
  a_retire_contig: assert property (
    ret_valid_r inside {3'b000, 3'b001, 3'b011, 3'b111}) else $error("retire skipped an entry");
  a_retire_rate: assert property (
    (ret_valid_r != '0) |=> (ret_valid_r == '0)) else $error("retire twice in a core cycle");
  a_redirect_empty: assert property (
    redirect_r |-> (cnt_r == '0 && iss_r == '0)) else $error("younger ops survive redirect");

  c_retire_three: cover property (ret_valid_r == 3'b111);
  c_redirect: cover property (redirect_r);
  c_fault: cover property (fault_r);
  c_alu_back2back: cover property (iss_r[0].valid ##1 iss_r[0].valid);
endmodule

// ### test/exec_pipe_model.sv
// Purpose: Behavioural execution pipelines answering issued micro-ops
// Assumes: One completion pulse per port per cycle; work dropped on redirect or fault
// Notes: slow_pc, exc_pc and mis_pc select commanded latency and outcomes
`timescale 1ns/1ps
`include "ooo_params.svh"
module exec_pipe_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire ooo_pkg::issue_t [`ISSUE_PORTS-1:0] iss,
  input wire logic redirect_r,
  input wire logic fault_r,
  input wire logic [31:0] slow_pc,
  input wire logic [31:0] exc_pc,
  input wire logic [31:0] mis_pc,
  input wire logic [31:0] act_tgt,
  output ooo_pkg::cmpl_t [`ISSUE_PORTS-1:0] cmp
);
  ooo_pkg::cmpl_t q[`ISSUE_PORTS][$];
  int due[`ISSUE_PORTS][$];
  int cyc = 0;
  initial cmp = '0;
  always @(posedge clk) begin
    ooo_pkg::cmpl_t c;
    ooo_pkg::uop_t u;
    cyc++;
    for (int p = 0; p < `ISSUE_PORTS; p++) begin
      u = iss[p].uop;
      if (!rst_n || redirect_r || fault_r) begin
        q[p].delete();
        due[p].delete();
      end else if (iss[p].valid === 1'b1) begin
        c = '0;
        c.valid = 1'b1;
        c.tag = iss[p].tag;
        c.exc = (u.pc == exc_pc);
        c.mispred = u.is_br && (u.pc == mis_pc);
        c.tgt = c.mispred ? act_tgt : u.pred_tgt;
        c.data = u.pc ^ 32'h0000a5a5;
        q[p].push_back(c);
        due[p].push_back(cyc + ((u.pc == slow_pc) ? 12 : 2));
      end
    end
    #1;
    for (int p = 0; p < `ISSUE_PORTS; p++) begin
      cmp[p] = '0;
      for (int i = 0; i < due[p].size(); i++) begin
        if (due[p][i] <= cyc) begin
          cmp[p] = q[p][i];
          q[p].delete(i);
          due[p].delete(i);
          break;
        end
      end
    end
  end
endmodule

// ### test/ooo_dispatch_retire_control_tb.sv
// Purpose: Self-checking bench for dispatch and retirement control
// Assumes: Execution pipelines modelled by exec_pipe_model
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`include "ooo_params.svh"
module ooo_dispatch_retire_control_tb;
  localparam logic [31:0] K = 32'h0000a5a5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fe_valid = 1'b0;
  ooo_pkg::uop_t fe_uop = '0;
  logic fe_ready, fetch_req, fetch_sector, trace_src_r, redirect_r, fault_r;
  logic [31:0] lk_pc = 32'h0;
  logic [31-`LINE_LSB:0] fetch_line;
  logic br_active = 1'b0;
  logic [31:0] br_next_pc = 32'h0;
  logic trace_wr = 1'b0;
  logic [31:0] trace_wr_pc = 32'h0;
  logic [1:0] trace_idx_r;
  ooo_pkg::issue_t [`ISSUE_PORTS-1:0] iss_r;
  ooo_pkg::cmpl_t [`ISSUE_PORTS-1:0] cmp;
  logic [`RETIRE_W-1:0] ret_valid_r, st_commit_r;
  logic [`ARCH_N-1:0][31:0] arch_r;
  logic [31:0] redirect_pc_r, fault_pc_r;
  logic [31:0] slow_pc = 32'hffffffff;
  logic [31:0] exc_pc = 32'hffffffff;
  logic [31:0] mis_pc = 32'hffffffff;
  logic [31:0] act_tgt = 32'h00012340;
  logic refused = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  int n_ret = 0, n_st = 0, n_redir = 0, n_fault = 0, n_alu = 0, max_ret = 0;
  int cyc = 0, last_fp = -100, min_fp = 1000;
  always #4 clk = ~clk;
  ooo_dispatch_retire_control uut (.clk, .rst_n, .fe_valid, .fe_uop, .fe_ready, .lk_pc, .fetch_req, .fetch_line,
    .fetch_sector, .br_active, .br_next_pc, .trace_wr, .trace_wr_pc, .trace_src_r, .trace_idx_r, .iss_r, .cmp,
    .ret_valid_r, .st_commit_r, .arch_r, .redirect_r, .redirect_pc_r, .fault_r, .fault_pc_r);
  exec_pipe_model pipes (.clk, .rst_n, .iss(iss_r), .redirect_r, .fault_r, .slow_pc, .exc_pc, .mis_pc, .act_tgt,
    .cmp);
  always @(posedge clk) begin
    cyc++;
    if (rst_n) begin
      n_ret += $countones(ret_valid_r);
      if ($countones(ret_valid_r) > max_ret) max_ret = $countones(ret_valid_r);
      n_st += $countones(st_commit_r);
      n_redir += int'(redirect_r === 1'b1);
      n_fault += int'(fault_r === 1'b1);
      refused |= (fe_ready === 1'b0);
      n_alu += int'(iss_r[0].valid === 1'b1) + int'(iss_r[1].valid === 1'b1);
      if (iss_r[3].valid === 1'b1 && iss_r[3].uop.cls == ooo_pkg::CLS_FP) begin
        if (cyc - last_fp < min_fp) min_fp = cyc - last_fp;
        last_fp = cyc;
      end
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic timeout();
    $display("[ERR] %0t wait limit reached", $time);
    n_errors++;
    test_done();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic ooo_pkg::uop_t mk(input logic [31:0] pc, input logic [1:0] cl, input logic [3:0] d,
    input logic br);
    mk = '0;
    mk.pc = pc;
    mk.cls = ooo_pkg::uop_cls_t'(cl);
    mk.is_br = br;
    mk.pred_tgt = pc + 32'h4;
    mk.has_dst = !br && cl != 2'h3;
    mk.dst = d;
  endfunction
  task automatic push(input ooo_pkg::uop_t u);
    int k;
    k = 0;
    fe_valid = 1'b1;
    fe_uop = u;
    while (fe_ready !== 1'b1 && k < 300) begin
      cycles(1);
      k++;
    end
    if (k == 300) timeout();
    cycles(1);
  endtask
  task automatic wait_for(ref int cnt, input int target);
    int k;
    k = 0;
    while (cnt < target && k < 500) begin
      cycles(1);
      k++;
    end
    if (k == 500) timeout();
  endtask
  task automatic branch_to(input logic [31:0] pc);
    br_active = 1'b1;
    br_next_pc = pc;
    cycles(2);
    br_active = 1'b0;
    cycles(1);
  endtask
  task automatic t_order();
    int b;
    b = n_ret;
    slow_pc = 32'h100;
    push(mk(32'h100, 2'h0, 4'h1, 1'b0));
    push(mk(32'h104, 2'h0, 4'h1, 1'b0));
    push(mk(32'h108, 2'h0, 4'h2, 1'b0));
    fe_valid = 1'b0;
    wait_for(n_ret, b + 3);
    check(arch_r[1], 32'h104 ^ K);
    check(arch_r[2], 32'h108 ^ K);
    check(32'(max_ret), 32'h3);
    slow_pc = 32'hffffffff;
    $display("test order done");
  endtask
  task automatic t_burst();
    int b, a;
    b = n_ret;
    a = n_alu;
    refused = 1'b0;
    for (int i = 0; i < 20; i++) push(mk(32'h200 + 32'(4 * i), 2'h0, 4'(i % 8), 1'b0));
    fe_valid = 1'b0;
    wait_for(n_ret, b + 20);
    check(32'(refused), 32'h1);
    check(32'(n_alu - a), 32'd20);
    check(32'(max_ret <= 3), 32'h1);
    check(arch_r[7], (32'h200 + 32'd60) ^ K);
    $display("test burst done");
  endtask
  task automatic t_mem();
    int b, s;
    b = n_ret;
    s = n_st;
    push(mk(32'h300, 2'h2, 4'h3, 1'b0));
    push(mk(32'h304, 2'h3, 4'h0, 1'b0));
    push(mk(32'h308, 2'h3, 4'h0, 1'b0));
    push(mk(32'h30c, 2'h1, 4'h9, 1'b0));
    push(mk(32'h310, 2'h1, 4'ha, 1'b0));
    push(mk(32'h314, 2'h1, 4'h9, 1'b0));
    fe_valid = 1'b0;
    wait_for(n_ret, b + 6);
    check(32'(n_st - s), 32'h2);
    check(arch_r[3], 32'h300 ^ K);
    check(arch_r[9], 32'h314 ^ K);
    check(32'(min_fp >= 4), 32'h1);
    $display("test memory done");
  endtask
  task automatic t_trace();
    trace_wr = 1'b1;
    trace_wr_pc = 32'h800;
    cycles(1);
    trace_wr_pc = 32'h880;
    cycles(1);
    trace_wr = 1'b0;
    branch_to(32'h880);
    check(32'(trace_src_r), 32'h1);
    check(32'(trace_idx_r), 32'h1);
    branch_to(32'h900);
    check(32'(trace_src_r), 32'h0);
    branch_to(32'h800);
    check(32'(trace_idx_r), 32'h0);
    $display("test trace done");
  endtask
  task automatic t_fault();
    int b, f;
    logic [31:0] o5, o6;
    b = n_ret;
    f = n_fault;
    o5 = arch_r[5];
    o6 = arch_r[6];
    exc_pc = 32'h504;
    push(mk(32'h500, 2'h0, 4'h4, 1'b0));
    push(mk(32'h504, 2'h0, 4'h5, 1'b0));
    push(mk(32'h508, 2'h0, 4'h6, 1'b0));
    fe_valid = 1'b0;
    wait_for(n_fault, f + 1);
    check(fault_pc_r, 32'h504);
    cycles(4);
    check(32'(n_ret - b), 32'h1);
    check(arch_r[5], o5);
    check(arch_r[6], o6);
    exc_pc = 32'hffffffff;
    $display("test fault done");
  endtask
  task automatic t_mispred();
    int b, r, k;
    logic [31:0] o6;
    b = n_ret;
    r = n_redir;
    o6 = arch_r[6];
    mis_pc = 32'h600;
    slow_pc = 32'h600;
    push(mk(32'h600, 2'h0, 4'h0, 1'b1));
    push(mk(32'h604, 2'h0, 4'h6, 1'b0));
    fe_valid = 1'b0;
    wait_for(n_redir, r + 1);
    check(redirect_pc_r, act_tgt);
    check(32'(trace_src_r), 32'h0);
    lk_pc = 32'h600;
    k = 0;
    while (fetch_req !== 1'b1 && k < 20) begin
      cycles(1);
      k++;
    end
    if (k == 20) timeout();
    check({6'h0, fetch_line}, act_tgt >> 6);
    check(32'(fetch_sector), 32'(act_tgt[6]));
    check(32'(n_ret - b), 32'h1);
    check(arch_r[6], o6);
    lk_pc = 32'h700;
    cycles(3);
    check(32'(fetch_req), 32'h0);
    mis_pc = 32'hffffffff;
    slow_pc = 32'hffffffff;
    $display("test mispredict done");
  endtask
  initial begin
    cycles(20);
    check(32'(fe_ready), 32'h1);
    check(32'(ret_valid_r), 32'h0);
    check(arch_r[3], 32'h0);
    rst_n = 1'b1;
    $display("test reset done");
    t_order();
    t_burst();
    t_mem();
    t_trace();
    t_fault();
    t_mispred();
    test_done();
  end
endmodule
